/* File: rtl/vlr_ctrl_regs.sv */
/*
 * Control and status registers of the voltage reference and
 * low-voltage detect unit, with Avalon-MM slave and interrupt.
 * Assumes analog inputs arrive asynchronously and the core clock
 * runs at 250 MHz.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
// Contract
// - Bandgap powered while any consumer needs it
// - High reference on by either enable or users
// - Low reference on by either enable or users
// - High reference to pin when both bits
// - Low reference to pin when both bits
// - Output enable clear keeps reference internal
// - Unimplemented bits ignore writes, read zero
// - Reset values: trip 0101, enables clear
`timescale 1ns/100ps
`include "vlr_consts.svh"

module vlr_ctrl_regs
    import vlr_pkg::*;
#(
    parameter int SETTLE_CYCLES = `VLR_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    // Avalon-MM slave
    input  wire logic [`VLR_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // Consumers asking for the bandgap, and the detector trip input
    input  wire logic                  brownout_reset_en_in,
    input  wire logic                  converter_ref_req_in,
    input  wire logic                  low_voltage_detector_trip_in,
    // Analog control
    output logic                       bandgap_power_out,
    output logic                       high_reference_power_out,
    output logic                       low_reference_power_out,
    output logic                       detector_power_out,
    output logic [3:0]                 trip_point_out,
    output logic                       high_reference_pin_out,
    output logic                       low_reference_pin_out,
    // Interrupt
    output logic                       irq_out
);

    // Refuse a zero settle count
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end


    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {low_voltage_detector_trip_in, converter_ref_req_in,
                          brownout_reset_en_in};
            sync2_reg <= sync1_reg;
        end
    end

    logic brownout_s;
    logic converter_s;
    logic trip_s;
    assign brownout_s  = sync2_reg[0];
    assign converter_s = sync2_reg[1];
    assign trip_s      = sync2_reg[2];

    // ****************************************
    // Bus decode
    // ****************************************
    vlr_bus_e   bus_state_reg;
    logic [7:0] idx;
    logic       wr_take;
    logic       rd_take;
    logic [7:0] wbyte;

    assign idx     = avs_address_in[`VLR_ADDR_W-1:2];
    assign wbyte   = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;
    assign wr_take = avs_write_in && (bus_state_reg == VLR_BUS_ACK)
                     && avs_byteenable_in[0];
    assign rd_take = avs_read_in && (bus_state_reg == VLR_BUS_IDLE);

    // One wait cycle, answered at the second edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_state_reg <= VLR_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                VLR_BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_state_reg <= VLR_BUS_ACK;
                    end
                end
                VLR_BUS_ACK: begin
                    bus_state_reg <= VLR_BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= VLR_BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest_out = (avs_read_in || avs_write_in)
                                 && (bus_state_reg != VLR_BUS_ACK);

    // ****************************************
    // Control registers
    // ****************************************
    logic [3:0] trip_reg;
    logic       det_power_reg;
    logic [3:0] ref_ctrl_reg;
    logic [`VLR_IRQ_W-1:0] irq_en_reg;
    logic [`VLR_IRQ_W-1:0] irq_stat_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trip_reg      <= `VLR_DET_TRIP_RESET;
            det_power_reg <= 1'b0;
        end else if (wr_take && idx == `VLR_IDX_DET_CTRL) begin
            trip_reg      <= wbyte[`VLR_DET_TRIP_MSB:`VLR_DET_TRIP_LSB];
            det_power_reg <= wbyte[`VLR_DET_POWER_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_ctrl_reg <= 4'h0;
        end else if (wr_take && idx == `VLR_IDX_REF_CTRL) begin
            ref_ctrl_reg <= wbyte[7:4];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_en_reg <= '0;
        end else if (wr_take && idx == `VLR_IDX_IRQ_ENABLE) begin
            irq_en_reg <= wbyte[`VLR_IRQ_W-1:0];
        end
    end

    logic high_en;
    logic low_en;
    logic high_oe;
    logic low_oe;
    assign high_en = ref_ctrl_reg[`VLR_REF_HIGH_EN_BIT-4];
    assign low_en  = ref_ctrl_reg[`VLR_REF_LOW_EN_BIT-4];
    assign high_oe = ref_ctrl_reg[`VLR_REF_HIGH_OE_BIT-4];
    assign low_oe  = ref_ctrl_reg[`VLR_REF_LOW_OE_BIT-4];

    // ****************************************
    // Power steering
    // ****************************************
    logic shared_users;
    logic bg_next;
    logic high_next;
    logic low_next;
    logic bg_reg;
    logic high_pwr_reg;
    logic low_pwr_reg;
    logic det_pwr_out_reg;
    logic high_pin_reg;
    logic low_pin_reg;
    logic [3:0] trip_out_reg;

    assign shared_users = det_power_reg || brownout_s;
    assign high_next = high_en || shared_users || low_en;
    assign low_next  = low_en || shared_users || high_en;
    assign bg_next   = det_power_reg || brownout_s || converter_s
                       || high_en || low_en;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bg_reg          <= 1'b0;
            high_pwr_reg    <= 1'b0;
            low_pwr_reg     <= 1'b0;
            det_pwr_out_reg <= 1'b0;
            trip_out_reg    <= `VLR_DET_TRIP_RESET;
        end else begin
            bg_reg          <= bg_next;
            high_pwr_reg    <= high_next;
            low_pwr_reg     <= low_next;
            det_pwr_out_reg <= det_power_reg;
            trip_out_reg    <= trip_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            high_pin_reg <= 1'b0;
            low_pin_reg  <= 1'b0;
        end else begin
            high_pin_reg <= high_oe && high_en;
            low_pin_reg  <= low_oe && low_en;
        end
    end

    assign bandgap_power_out        = bg_reg;
    assign high_reference_power_out = high_pwr_reg;
    assign low_reference_power_out  = low_pwr_reg;
    assign detector_power_out       = det_pwr_out_reg;
    assign trip_point_out           = trip_out_reg;
    assign high_reference_pin_out   = high_pin_reg;
    assign low_reference_pin_out    = low_pin_reg;

    // ****************************************
    // Bandgap settle timer
    // ****************************************
    vlr_settle_if st_if ();
    assign st_if.power_on = bg_reg;

    vlr_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .st      (st_if.timer)
    );

    logic stable;
    logic stable_d_reg;
    assign stable = st_if.stable;

    // ****************************************
    // Interrupt status
    // ****************************************
    logic [`VLR_IRQ_W-1:0] ev;
    logic [`VLR_IRQ_W-1:0] clr;
    logic                  trip_rsv;

    assign trip_rsv = (trip_reg < `VLR_TRIP_MIN_CODE)
                      || (trip_reg > `VLR_TRIP_MAX_CODE);
    assign ev[`VLR_IRQ_DETECT_BIT]   = trip_s && det_power_reg && stable;
    assign ev[`VLR_IRQ_STABLE_BIT]   = stable && !stable_d_reg;
    assign ev[`VLR_IRQ_TRIP_RSV_BIT] = wr_take && idx == `VLR_IDX_DET_CTRL
        && ((wbyte[3:0] < `VLR_TRIP_MIN_CODE) || (wbyte[3:0] > `VLR_TRIP_MAX_CODE));
    assign clr = (wr_take && idx == `VLR_IDX_IRQ_CLEAR) ? wbyte[`VLR_IRQ_W-1:0] : '0;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stable_d_reg <= 1'b0;
        end else begin
            stable_d_reg <= stable;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
        end
    end

    assign irq_out = |(irq_stat_reg & irq_en_reg);

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (idx == `VLR_IDX_DET_CTRL) begin
            rd_byte = {2'b00, stable, det_power_reg, trip_reg};
        end else if (idx == `VLR_IDX_REF_CTRL) begin
            rd_byte = {ref_ctrl_reg, 4'h0};
        end else if (idx == `VLR_IDX_IRQ_STATUS) begin
            rd_byte = {5'h00, irq_stat_reg};
        end else if (idx == `VLR_IDX_IRQ_ENABLE) begin
            rd_byte = {5'h00, irq_en_reg};
        end else if (idx == `VLR_IDX_DEP_STATUS) begin
            rd_byte = {3'h0, low_pwr_reg, high_pwr_reg, det_pwr_out_reg,
                       bg_reg, trip_rsv};
        end else if (idx == `VLR_IDX_DETECT_LEVEL) begin
            rd_byte = {5'h00, converter_s, brownout_s, trip_s};
        end
    end

    logic [31:0] rdata_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    assign avs_readdata_out = rdata_reg;

endmodule // vlr_ctrl_regs

/* File: rtl/vlr_consts.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * of the reference and low-voltage detect control block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef VLR_CONSTS_SVH
`define VLR_CONSTS_SVH

// ****************************************
// Register indices and bus address width
// ****************************************
`define VLR_IDX_REF_CTRL      8'h9B
`define VLR_IDX_DET_CTRL      8'h9C
`define VLR_IDX_IRQ_STATUS    8'hA0
`define VLR_IDX_IRQ_ENABLE    8'hA1
`define VLR_IDX_IRQ_CLEAR     8'hA2
`define VLR_IDX_DEP_STATUS    8'hA3
`define VLR_IDX_DETECT_LEVEL  8'hA4
`define VLR_ADDR_W            10

// ****************************************
// Detect control fields
// ****************************************
`define VLR_DET_TRIP_LSB      0
`define VLR_DET_TRIP_MSB      3
`define VLR_DET_POWER_BIT     4
`define VLR_DET_STABLE_BIT    5
`define VLR_DET_WR_MASK       8'h1F
`define VLR_DET_TRIP_RESET    4'h5

// ****************************************
// Reference control fields
// ****************************************
`define VLR_REF_LOW_OE_BIT    4
`define VLR_REF_HIGH_OE_BIT   5
`define VLR_REF_LOW_EN_BIT    6
`define VLR_REF_HIGH_EN_BIT   7
`define VLR_REF_WR_MASK       8'hF0
`define VLR_REF_RESET         8'h00

// ****************************************
// Interrupt status bits
// ****************************************
`define VLR_IRQ_W             3
`define VLR_IRQ_DETECT_BIT    0
`define VLR_IRQ_STABLE_BIT    1
`define VLR_IRQ_TRIP_RSV_BIT  2

// ****************************************
// Timing and trip code range
// ****************************************
`define VLR_CLK_MHZ           250
`define VLR_SETTLE_US         20
`define VLR_SETTLE_CYCLES     (`VLR_SETTLE_US * `VLR_CLK_MHZ)
`define VLR_TRIP_MIN_CODE     4'h4
`define VLR_TRIP_MAX_CODE     4'hE

`endif

/* File: rtl/vlr_pkg.sv */
/*
 * Types of the reference and low-voltage detect control block.
 * Assumes the constants header is on the include path.
 */
package vlr_pkg;
`include "vlr_consts.svh"

    typedef enum logic [1:0] {
        VLR_BUS_IDLE = 2'b00,
        VLR_BUS_ACK  = 2'b01
    } vlr_bus_e;

    typedef logic [7:0] vlr_byte_t;

endpackage

/* File: rtl/vlr_sync_if.sv */
/*
 * Carrier between the top and its settle timer.
 * Assumes a single clock domain.
 */
`timescale 1ns/100ps

interface vlr_settle_if;
    logic power_on;
    logic stable;

    modport owner (output power_on, input stable);
    modport timer (input power_on, output stable);
endinterface

/* File: rtl/vlr_settle_timer.sv */
/*
 * Bandgap settle timer: raises stable a fixed count after power on.
 * Assumes power_on comes from logic on the same clock.
 */
`timescale 1ns/100ps

module vlr_settle_timer #(
    parameter int SETTLE_CYCLES = 5000
) (
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    // Carrier
    vlr_settle_if.timer st
);

    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    logic [CW-1:0] count_reg;
    logic          stable_reg;

    // Refuse a zero settle count
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg <= '0;
        end else if (!st.power_on) begin
            count_reg <= '0;
        end else if (count_reg != CW'(SETTLE_CYCLES)) begin
            count_reg <= count_reg + CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stable_reg <= 1'b0;
        end else begin
            stable_reg <= st.power_on && (count_reg == CW'(SETTLE_CYCLES));
        end
    end

    assign st.stable = stable_reg;

endmodule // vlr_settle_timer

/* File: verification/vlr_ctrl_properties.sv */
/* Port checker of the reference and detect control block.
   Assumes a bind onto vlr_ctrl_regs and a single clock. */
`timescale 1ns/100ps
`include "vlr_consts.svh"
// ****************************************
// Checker
// ****************************************
module vlr_ctrl_chk
    import vlr_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8
) (
    // Clock and reset
    input wire logic                   clk_in,
    input wire logic                   rstn_in,
    // Bus
    input wire logic [`VLR_ADDR_W-1:0] avs_address_in,
    input wire logic                   avs_write_in,
    input wire logic                   avs_read_in,
    input wire logic [31:0]            avs_writedata_in,
    input wire logic [3:0]             avs_byteenable_in,
    input wire logic [31:0]            avs_readdata_out,
    input wire logic                   avs_waitrequest_out,
    // Consumers and controls
    input wire logic                   brownout_reset_en_in,
    input wire logic                   converter_ref_req_in,
    input wire logic                   bandgap_power_out,
    input wire logic                   high_reference_power_out,
    input wire logic                   low_reference_power_out,
    input wire logic                   detector_power_out,
    input wire logic [3:0]             trip_point_out,
    input wire logic                   high_reference_pin_out,
    input wire logic                   low_reference_pin_out
);
    logic [15:0] bg_cnt_reg;
    wire        done = !avs_waitrequest_out && avs_byteenable_in[0];
    wire        ref_wr = avs_write_in && done && avs_address_in == 10'h26C;
    wire        det_rd = avs_read_in && !avs_waitrequest_out && avs_address_in == 10'h270;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) bg_cnt_reg <= 16'h0000;
        else if (!bandgap_power_out) bg_cnt_reg <= 16'h0000;
        else if (bg_cnt_reg != 16'hFFFF) bg_cnt_reg <= bg_cnt_reg + 16'h0001;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_reset_trip_value: assert property ($rose(rstn_in) |->
        trip_point_out == 4'h5 && !bandgap_power_out) else $error("reset state");
    a_high_pin_power: assert property (high_reference_pin_out |->
        high_reference_power_out) else $error("high pin unpowered");
    a_low_pin_power: assert property (low_reference_pin_out |->
        low_reference_power_out) else $error("low pin unpowered");
    a_pin_kept_internal: assert property (ref_wr && !avs_writedata_in[5] |->
        ##[1:3] !high_reference_pin_out) else $error("high pin driven");
    a_detector_bandgap: assert property (detector_power_out |->
        bandgap_power_out) else $error("detector without bandgap");
    a_bandgap_idle: assert property ((!brownout_reset_en_in && !converter_ref_req_in
        && !high_reference_power_out && !detector_power_out)[*5] |-> !bandgap_power_out)
        else $error("bandgap on idle");
    a_high_ref_on: assert property (ref_wr && avs_writedata_in[7] |->
        ##[1:3] high_reference_power_out) else $error("high ref off");
    a_low_ref_on: assert property (ref_wr && avs_writedata_in[6] |->
        ##[1:3] low_reference_power_out) else $error("low ref off");
    a_read_zero_bits: assert property (det_rd |->
        avs_readdata_out[31:6] == 26'h0 || avs_readdata_out[31:5] == 27'h1)
        else $error("unused bits set");
    a_stable_settled: assert property (det_rd && avs_readdata_out[5] |->
        bg_cnt_reg >= SETTLE_CYCLES || !bandgap_power_out) else $error("early stable");
endmodule // vlr_ctrl_chk

bind vlr_ctrl_regs vlr_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_write_in(avs_write_in), .avs_read_in(avs_read_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .brownout_reset_en_in(brownout_reset_en_in), .converter_ref_req_in(converter_ref_req_in),
    .bandgap_power_out(bandgap_power_out), .high_reference_power_out(high_reference_power_out),
    .low_reference_power_out(low_reference_power_out), .detector_power_out(detector_power_out),
    .trip_point_out(trip_point_out), .high_reference_pin_out(high_reference_pin_out),
    .low_reference_pin_out(low_reference_pin_out));

/* File: verification/tb.sv */
/* Self-checking bench: registers, outputs, settle flag, interrupt.
   Assumes design and checker files are compiled first. */
`timescale 1ns/100ps
// ****************************************
// Bench
// ****************************************
module tb;
    import vlr_pkg::*;
    logic        clk_in = 1'h0;
    logic        rstn_in = 1'h0;
    logic [9:0]  adr = 10'h000;
    logic        rd = 1'h0;
    logic        wr = 1'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        bo = 1'h0;
    logic        cv = 1'h0;
    logic        trp = 1'h0;
    logic [31:0] rdat;
    logic        wt;
    logic        irq;
    logic [9:0]  outs;
    logic [31:0] q;
    logic [7:0]  rv;
    logic [7:0]  dv;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    always #2 clk_in = ~clk_in;
    vlr_ctrl_regs #(.SETTLE_CYCLES(8)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .brownout_reset_en_in(bo), .converter_ref_req_in(cv),
        .low_voltage_detector_trip_in(trp), .bandgap_power_out(outs[9]),
        .high_reference_power_out(outs[8]), .low_reference_power_out(outs[7]),
        .detector_power_out(outs[6]), .high_reference_pin_out(outs[5]),
        .low_reference_pin_out(outs[4]), .trip_point_out(outs[3:0]), .irq_out(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        do begin
            @(posedge clk_in);
        end while (wt !== 1'h0);
        q = rdat;
        wr <= 1'h0;
        rd <= 1'h0;
    endtask
    function automatic logic [9:0] exp_out(input logic [7:0] r, input logic [7:0] d);
        logic rp;
        rp = r[7] | r[6] | d[4] | bo;
        return {rp | cv, rp, rp, d[4], r[7] & r[5], r[6] & r[4], d[3:0]};
    endfunction
    task automatic tend(input string s);
        $display("test %s ends, errors %0d", s, error_cnt);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h4ECE0E11));
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'h1;
        chk({22'h0, outs}, 32'h5);
        bus(0, 10'h270, 8'h00);
        chk(q, 32'h5);
        bus(0, 10'h26C, 8'h00);
        chk(q, 32'h0);
        tend("reset");
        bus(1, 10'h26C, 8'h0F);
        bus(0, 10'h26C, 8'h00);
        chk(q, 32'h0);
        bus(1, 10'h270, 8'hC4);
        be <= 4'hE;
        bus(1, 10'h270, 8'h0A);
        be <= 4'hF;
        bus(0, 10'h270, 8'h00);
        chk(q, 32'h4);
        bus(1, 10'h000, 8'hFF);
        bus(0, 10'h000, 8'h00);
        chk(q, 32'h0);
        tend("refuse");
        for (int i = 0; i < 24; i++) begin
            rv = {4'($urandom_range(15, 0)), 4'h0};
            dv = {3'h0, 1'($urandom_range(1, 0)), 4'($urandom_range(14, 4))};
            bo <= 1'($urandom_range(1, 0));
            cv <= 1'($urandom_range(1, 0));
            if (i < 2) begin
                rv = 8'h00;
                dv = 8'h05;
                bo <= 1'h0;
                cv <= i[0];
            end
            bus(1, 10'h26C, rv);
            bus(1, 10'h270, dv);
            repeat (4) @(posedge clk_in);
            chk({22'h0, outs}, {22'h0, exp_out(rv, dv)});
            bus(0, 10'h26C, 8'h00);
            chk(q, {24'h0, rv});
            bus(0, 10'h270, 8'h00);
            chk(q & 32'hDF, {24'h0, dv});
        end
        tend("random");
        bo <= 1'h0;
        cv <= 1'h0;
        bus(1, 10'h26C, 8'h00);
        bus(1, 10'h270, 8'h05);
        repeat (6) @(posedge clk_in);
        bus(1, 10'h288, 8'h07);
        bus(1, 10'h284, 8'h07);
        bus(0, 10'h280, 8'h00);
        chk({q[31:1], irq}, 32'h0);
        bus(1, 10'h270, 8'h15);
        bus(0, 10'h270, 8'h00);
        chk(q, 32'h15);
        repeat (20) @(posedge clk_in);
        bus(0, 10'h270, 8'h00);
        chk(q, 32'h35);
        bus(0, 10'h280, 8'h00);
        chk({q[31:1], irq}, 32'h3);
        bus(1, 10'h288, 8'h02);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        trp <= 1'h1;
        repeat (6) @(posedge clk_in);
        bus(0, 10'h280, 8'h00);
        chk({q[31:1], irq}, 32'h1);
        bus(1, 10'h284, 8'h00);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        trp <= 1'h0;
        repeat (4) @(posedge clk_in);
        bus(1, 10'h288, 8'h07);
        bus(0, 10'h280, 8'h00);
        chk(q, 32'h0);
        bus(1, 10'h270, 8'h13);
        bus(0, 10'h280, 8'h00);
        chk(q, 32'h4);
        bus(0, 10'h28C, 8'h00);
        chk(q, 32'h1F);
        bus(0, 10'h288, 8'h00);
        chk(q, 32'h0);
        cv <= 1'h1;
        repeat (4) @(posedge clk_in);
        bus(0, 10'h290, 8'h00);
        chk(q, 32'h4);
        cv <= 1'h0;
        tend("interrupt");
        give_verdict();
    end
endmodule // tb
